// ==== rtl/sdram_cmd_pkg.sv ====
// Constants and types for the synchronous DRAM command decoder
// Function
// - Chip select low enables decode; high ignores
// - Strobes and write enable sampled at rising edge
// - Activate captures eleven-bit row address
// - Column from low bits, top bit per width
// - Bit 10 selects auto precharge, 11 bank
// - Precharge bit 10 both banks, else one
// - Bank select low bank A, high B
// - Read mask floats data three cycles later
// - Write mask blocks write same edge
// - Chip select high standby; all high no-op
// - Row low only decodes bank activate
// - Column low decodes read or write
// - Precharge, stop, self refresh, mode set decode
// - Mode register holds latency, length, order
// - Mode set loads fields from address
// - Clock gate low blocks commands and holds the burst; mask pipe keeps shifting
// - Burst length 1, 2, 4, 8 or page
// - Page burst sequential only, never ends itself
package sdram_cmd_pkg;

	// ---------------------------------------------------------------
	// Address field positions
	// ---------------------------------------------------------------
	localparam int ADDR_W       = 12;
	localparam int ROW_W        = 11;
	localparam int COL_W        = 10;
	localparam int AP_BIT       = 10;
	localparam int BANK_BIT     = 11;
	localparam int BL_LSB       = 0;
	localparam int BL_W         = 3;
	localparam int BT_BIT       = 3;
	localparam int CL_LSB       = 4;
	localparam int CL_W         = 3;
	localparam int MASK_RD_LAT  = 2;

	// ---------------------------------------------------------------
	// Mode field encodings and reset values
	// ---------------------------------------------------------------
	localparam logic [2:0] BL_1    = 3'h0;
	localparam logic [2:0] BL_2    = 3'h1;
	localparam logic [2:0] BL_4    = 3'h2;
	localparam logic [2:0] BL_8    = 3'h3;
	localparam logic [2:0] BL_PAGE = 3'h7;
	localparam logic [2:0] CL_RST  = 3'h2;
	localparam logic [8:0] CNT_ONE = 9'h001;
	localparam logic [8:0] CNT_ZERO = 9'h000;

	// Decoded command on the bus
	typedef enum logic [2:0] {
		CMD_NOP    = 3'h0,
		CMD_ACT    = 3'h1,
		CMD_READ   = 3'h2,
		CMD_WRITE  = 3'h3,
		CMD_PRE    = 3'h4,
		CMD_STOP   = 3'h5,
		CMD_SREF   = 3'h6,
		CMD_MODE   = 3'h7
	} cmd_e;

	// Burst engine state, Gray along idle-read-write; write-idle flips both bits
	typedef enum logic [1:0] {
		ST_IDLE  = 2'h0,
		ST_READ  = 2'h1,
		ST_WRITE = 2'h3
	} burst_e;

	// Burst length in words for a length code; zero means page
	function automatic logic [8:0] burst_words(input logic [2:0] code);
		case (code)
			BL_1:    burst_words = 9'h001;
			BL_2:    burst_words = 9'h002;
			BL_4:    burst_words = 9'h004;
			BL_8:    burst_words = 9'h008;
			default: burst_words = 9'h000;
		endcase
	endfunction

endpackage

// ==== rtl/sdram_command_interface.sv ====
// Command decoder, address capture, mode register and data mask timing
`timescale 1ns/10ps
module sdram_command_interface
	import sdram_cmd_pkg::*;
#(
	parameter int COL_TOP = 9
) (
	input  wire logic              clk_sys_in,
	input  wire logic              sys_rst_in,
	input  wire logic              clock_gate_in,
	input  wire logic              chip_select_n_in,
	input  wire logic              row_strobe_n_in,
	input  wire logic              col_strobe_n_in,
	input  wire logic              write_enable_n_in,
	input  wire logic [ADDR_W-1:0] address_in,
	input  wire logic              byte_mask_in,
	output logic [2:0]             cmd_out,
	output logic                   cmd_valid_out,
	output logic [ROW_W-1:0]       row_address_out,
	output logic [COL_W-1:0]       column_address_out,
	output logic                   bank_select_out,
	output logic                   auto_precharge_out,
	output logic [1:0]             bank_open_out,
	output logic [1:0]             precharge_banks_out,
	output logic [2:0]             cas_latency_out,
	output logic [2:0]             burst_len_out,
	output logic                   burst_interleave_out,
	output logic                   read_active_out,
	output logic                   write_active_out,
	output logic                   data_oe_out,
	output logic                   write_strobe_out,
	output logic                   self_refresh_out
);

	initial begin
		if (COL_TOP != 9 && COL_TOP != 7) begin
			$error("COL_TOP must be 9 or 7");
		end
	end

	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	// Two stages on every pin; the first stage feeds only the second
	logic [ADDR_W+5:0] pin_meta_ff;
	logic [ADDR_W+5:0] pin_sync_ff;
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			pin_meta_ff <= {(ADDR_W+6){1'b1}};
			pin_sync_ff <= {(ADDR_W+6){1'b1}};
		end else begin
			pin_meta_ff <= {clock_gate_in, chip_select_n_in, row_strobe_n_in,
				col_strobe_n_in, write_enable_n_in, byte_mask_in, address_in};
			pin_sync_ff <= pin_meta_ff;
		end
	end

	logic              cke_s;
	logic              cs_n_s;
	logic              ras_n_s;
	logic              cas_n_s;
	logic              we_n_s;
	logic              mask_s;
	logic [ADDR_W-1:0] addr_s;
	assign {cke_s, cs_n_s, ras_n_s, cas_n_s, we_n_s, mask_s, addr_s} = pin_sync_ff;

	// ---------------------------------------------------------------
	// Command decode
	// ---------------------------------------------------------------
	// A low clock gate blocks decode and holds the burst, so no command counts then
	cmd_e nxt_cmd;
	logic nxt_valid;
	always_comb begin
		nxt_valid = cke_s && !cs_n_s;
		case ({ras_n_s, cas_n_s, we_n_s})
			3'b111:  nxt_cmd = CMD_NOP;
			3'b011:  nxt_cmd = CMD_ACT;
			3'b101:  nxt_cmd = CMD_READ;
			3'b100:  nxt_cmd = CMD_WRITE;
			3'b010:  nxt_cmd = CMD_PRE;
			3'b110:  nxt_cmd = CMD_STOP;
			3'b001:  nxt_cmd = CMD_SREF;
			3'b000:  nxt_cmd = CMD_MODE;
			default: nxt_cmd = CMD_NOP;
		endcase
		if (cs_n_s) begin
			nxt_cmd = CMD_NOP;
		end
	end

	// Registered command report
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			cmd_out       <= CMD_NOP;
			cmd_valid_out <= 1'b0;
		end else begin
			cmd_out       <= nxt_valid ? nxt_cmd : CMD_NOP;
			cmd_valid_out <= nxt_valid;
		end
	end

	logic is_act;
	logic is_rd;
	logic is_wr;
	logic is_pre;
	logic is_stop;
	logic is_mode;
	logic is_sref;
	assign is_act  = nxt_valid && nxt_cmd == CMD_ACT;
	assign is_rd   = nxt_valid && nxt_cmd == CMD_READ;
	assign is_wr   = nxt_valid && nxt_cmd == CMD_WRITE;
	assign is_pre  = nxt_valid && nxt_cmd == CMD_PRE;
	assign is_stop = nxt_valid && nxt_cmd == CMD_STOP;
	assign is_mode = nxt_valid && nxt_cmd == CMD_MODE;
	assign is_sref = nxt_valid && nxt_cmd == CMD_SREF;

	// ---------------------------------------------------------------
	// Address capture
	// ---------------------------------------------------------------
	// Row held until the next activate, column until the next read or write; bank reloads on either
	logic [COL_W-1:0] col_mask;
	assign col_mask = (COL_TOP == 9) ? 10'h3FF : 10'h0FF;
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			row_address_out    <= '0;
			column_address_out <= '0;
			bank_select_out    <= 1'b0;
			auto_precharge_out <= 1'b0;
		end else begin
			if (is_act) begin
				row_address_out <= addr_s[ROW_W-1:0];
				bank_select_out <= addr_s[BANK_BIT];
			end
			if (is_rd || is_wr) begin
				column_address_out <= addr_s[COL_W-1:0] & col_mask;
				auto_precharge_out <= addr_s[AP_BIT];
				bank_select_out    <= addr_s[BANK_BIT];
			end
		end
	end

	// ---------------------------------------------------------------
	// Bank state
	// ---------------------------------------------------------------
	// Auto precharge closes the bank when the burst runs out
	logic [1:0] pre_req;
	logic       burst_done;
	always_comb begin
		pre_req = 2'b00;
		if (is_pre) begin
			if (addr_s[AP_BIT]) begin
				pre_req = 2'b11;
			end else begin
				pre_req[addr_s[BANK_BIT]] = 1'b1;
			end
		end
		if (burst_done && auto_precharge_out) begin
			pre_req[bank_select_out] = 1'b1;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			bank_open_out       <= 2'b00;
			precharge_banks_out <= 2'b00;
		end else begin
			precharge_banks_out <= pre_req;
			bank_open_out       <= bank_open_out & ~pre_req;
			if (is_act) begin
				bank_open_out[addr_s[BANK_BIT]] <= 1'b1;
			end
		end
	end

	// ---------------------------------------------------------------
	// Mode register
	// ---------------------------------------------------------------
	// Page length with interleave is not allowed, so fall back to sequential
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			cas_latency_out      <= CL_RST;
			burst_len_out        <= BL_1;
			burst_interleave_out <= 1'b0;
		end else if (is_mode) begin
			cas_latency_out      <= addr_s[CL_LSB +: CL_W];
			burst_len_out        <= addr_s[BL_LSB +: BL_W];
			burst_interleave_out <= addr_s[BT_BIT] &&
				addr_s[BL_LSB +: BL_W] != BL_PAGE;
		end
	end

	// ---------------------------------------------------------------
	// Burst engine
	// ---------------------------------------------------------------
	// Runs through standby cycles; a new column command restarts it
	burst_e     burst_st_ff;
	logic [8:0] burst_cnt_ff;
	logic [8:0] words;
	assign words      = burst_words(burst_len_out);
	assign burst_done = burst_st_ff != ST_IDLE && cke_s && words != CNT_ZERO &&
		burst_cnt_ff == CNT_ONE;
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			burst_st_ff  <= ST_IDLE;
			burst_cnt_ff <= CNT_ZERO;
		end else if (is_rd || is_wr) begin
			burst_st_ff  <= is_rd ? ST_READ : ST_WRITE;
			burst_cnt_ff <= words;
		end else if (is_stop || is_pre) begin
			burst_st_ff  <= ST_IDLE;
		end else if (cke_s) begin
			case (burst_st_ff)
				ST_IDLE: burst_st_ff <= ST_IDLE;
				ST_READ, ST_WRITE: begin
					if (burst_done) begin
						burst_st_ff <= ST_IDLE;
					end
					burst_cnt_ff <= burst_cnt_ff - CNT_ONE;
				end
				default: burst_st_ff <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			read_active_out  <= 1'b0;
			write_active_out <= 1'b0;
		end else begin
			read_active_out  <= burst_st_ff == ST_READ;
			write_active_out <= burst_st_ff == ST_WRITE;
		end
	end

	// ---------------------------------------------------------------
	// Data mask timing
	// ---------------------------------------------------------------
	// Read mask travels a two-stage pipe and the output register, so data floats three edges later
	logic [MASK_RD_LAT-1:0] mask_pipe_ff;
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			mask_pipe_ff <= '0;
		end else begin
			mask_pipe_ff <= {mask_pipe_ff[MASK_RD_LAT-2:0], mask_s};
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			data_oe_out      <= 1'b0;
			write_strobe_out <= 1'b0;
		end else begin
			data_oe_out      <= burst_st_ff == ST_READ && !mask_pipe_ff[MASK_RD_LAT-1];
			// The command edge carries the first word, so the final count edge adds none
			write_strobe_out <= (is_wr || (burst_st_ff == ST_WRITE && cke_s &&
				!is_rd && !is_stop && !is_pre && !burst_done)) && !mask_s;
		end
	end

	// ---------------------------------------------------------------
	// Self refresh
	// ---------------------------------------------------------------
	// Held while the clock gate stays low; clears on the first cycle it is high
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			self_refresh_out <= 1'b0;
		end else if (is_sref) begin
			self_refresh_out <= 1'b1;
		end else if (cke_s) begin
			self_refresh_out <= 1'b0;
		end
	end

endmodule

// ==== test/sdram_ctrl_model.sv ====
// Memory controller model that drives the command pins of the decoder
`timescale 1ns/10ps
module sdram_ctrl_model (
	input  wire logic        clk_in,
	output logic             gate_out,
	output logic             mask_out,
	output logic [3:0]       pins_out,
	output logic [11:0]      addr_out
);
	logic moded;

	// Pins start in standby with the clock running
	initial begin
		moded = 1'b0;
		gate_out = 1'b1;
		mask_out = 1'b0;
		pins_out = 4'hF;
		addr_out = 12'h000;
	end

	// One command for a whole cycle, then standby with the address inverted
	task automatic issue(input logic [3:0] p, input logic [11:0] a);
		@(negedge clk_in);
		if (p == 4'h3 && !moded)
			p = 4'h7;
		pins_out = p;
		addr_out = a;
		@(negedge clk_in);
		pins_out = 4'hF;
		addr_out = ~a;
	endtask

	// Close both banks with the gate high, load the mode, then a no-op
	task automatic set_mode(input logic [11:0] a);
		gate_out = 1'b1;
		issue(4'h2, 12'h400);
		issue(4'h0, a);
		issue(4'h7, ~a);
		moded = 1'b1;
	endtask
endmodule

// ==== test/sdram_cmd_properties.sv ====
// Port assertions for the command decoder
`timescale 1ns/10ps
module sdram_cmd_properties
	import sdram_cmd_pkg::*;
#(
	parameter int COL_TOP = 9
) (
	input wire logic        clk_sys_in,
	input wire logic        sys_rst_in,
	input wire logic        clock_gate_in,
	input wire logic        chip_select_n_in,
	input wire logic        row_strobe_n_in,
	input wire logic        col_strobe_n_in,
	input wire logic        write_enable_n_in,
	input wire logic [11:0] address_in,
	input wire logic        byte_mask_in,
	input wire logic [2:0]  cmd_out,
	input wire logic        cmd_valid_out,
	input wire logic [10:0] row_address_out,
	input wire logic [9:0]  column_address_out,
	input wire logic        bank_select_out,
	input wire logic        auto_precharge_out,
	input wire logic [1:0]  precharge_banks_out,
	input wire logic [2:0]  cas_latency_out,
	input wire logic [2:0]  burst_len_out,
	input wire logic        burst_interleave_out,
	input wire logic        write_strobe_out
);
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (sys_rst_in);

	logic [17:0] d1, d2, d3;
	wire         ok = d3[17] && !d3[15];
	wire  [2:0]  dc = dec(d3[14:12]);
	wire  [11:0] a  = d3[11:0];
	wire  [9:0]  cm = 10'h3FF >> (9 - COL_TOP);

	// Pins three edges back line up with the outputs seen now
	always_ff @(posedge clk_sys_in) begin
		{d3, d2, d1} <= {d2, d1, clock_gate_in, byte_mask_in, chip_select_n_in,
			row_strobe_n_in, col_strobe_n_in, write_enable_n_in, address_in};
	end

	function automatic logic [2:0] dec(input logic [2:0] s);
		case (s)
			3'h3: return CMD_ACT;
			3'h5: return CMD_READ;
			3'h4: return CMD_WRITE;
			3'h2: return CMD_PRE;
			3'h6: return CMD_STOP;
			3'h1: return CMD_SREF;
			3'h0: return CMD_MODE;
			default: return CMD_NOP;
		endcase
	endfunction

	property p_refuse;
		!ok |-> !cmd_valid_out && cmd_out == CMD_NOP;
	endproperty
	a_refuse: assert property (p_refuse) else $error("refused cycle gave a command");
	property p_decode;
		ok |-> cmd_valid_out && cmd_out == dc;
	endproperty
	a_decode: assert property (p_decode) else $error("wrong command decode");
	property p_row;
		ok && dc == CMD_ACT |-> row_address_out == a[10:0] && bank_select_out == a[11];
	endproperty
	a_row: assert property (p_row) else $error("row or bank not captured");
	property p_col;
		ok && dc inside {CMD_READ, CMD_WRITE} |-> column_address_out == (a[9:0] & cm);
	endproperty
	a_col: assert property (p_col) else $error("column not captured");
	property p_ap;
		ok && dc inside {CMD_READ, CMD_WRITE} |-> auto_precharge_out == a[10];
	endproperty
	a_ap: assert property (p_ap) else $error("auto precharge flag wrong");
	property p_pre;
		ok && dc == CMD_PRE |-> (precharge_banks_out & {a[10] | a[11], a[10] | !a[11]}) != 2'h0;
	endproperty
	a_pre: assert property (p_pre) else $error("precharge banks wrong");
	property p_mode;
		ok && dc == CMD_MODE |-> burst_len_out == a[2:0] && cas_latency_out == a[6:4]
			&& burst_interleave_out == (a[3] && a[2:0] != BL_PAGE);
	endproperty
	a_mode: assert property (p_mode) else $error("mode fields not loaded");
	property p_wmask;
		ok && dc == CMD_WRITE |-> write_strobe_out == !d3[16];
	endproperty
	a_wmask: assert property (p_wmask) else $error("write mask ignored");

	c_act: cover property (ok && dc == CMD_ACT);
	c_mode: cover property (ok && dc == CMD_MODE);
	c_wmask: cover property (ok && dc == CMD_WRITE && d3[16]);
endmodule

// ==== test/tb_sdram_command_interface.sv ====
// Self-checking bench for the command decoder
`timescale 1ns/10ps
module tb_sdram_command_interface;
	import sdram_cmd_pkg::*;
	localparam int         CT = 7;
	localparam logic [3:0] PINS [9] = '{4'h7, 4'h3, 4'h5, 4'h4, 4'h2, 4'h6, 4'h1, 4'h0, 4'hF};
	localparam logic [2:0] BLC [5] = '{3'h7, 3'h0, 3'h1, 3'h2, 3'h3};

	logic clk_sys_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic clock_gate_in, byte_mask_in, cmd_valid_out, bank_select_out, auto_precharge_out;
	logic burst_interleave_out, read_active_out, write_active_out, data_oe_out;
	logic write_strobe_out, self_refresh_out;
	logic chip_select_n_in, row_strobe_n_in, col_strobe_n_in, write_enable_n_in;
	logic [3:0]  pins;
	logic [11:0] address_in, m;
	logic [2:0]  cmd_out, cas_latency_out, burst_len_out;
	logic [10:0] row_address_out;
	logic [9:0]  column_address_out;
	logic [1:0]  bank_open_out, precharge_banks_out, opn;
	int          n_fail, cmp_count, k;
	int          seed = 32'hDDE10F43;

	assign {chip_select_n_in, row_strobe_n_in, col_strobe_n_in, write_enable_n_in} = pins;
	always #5 clk_sys_in = ~clk_sys_in;

	sdram_command_interface #(.COL_TOP(CT)) u_sdram_command_interface (.*);
	sdram_ctrl_model u_sdram_ctrl_model (.clk_in(clk_sys_in), .gate_out(clock_gate_in),
		.mask_out(byte_mask_in), .pins_out(pins), .addr_out(address_in));

	function automatic logic [1:0] pre_banks(input logic [11:0] a);
		return a[10] ? 2'h3 : (a[11] ? 2'h2 : 2'h1);
	endfunction

	task automatic check(input logic [11:0] got, input logic [11:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch t=%0t got=%0h exp=%0h", $time, got, exp);
		end
	endtask

	// Outputs land two edges after the pin edge and pulses stand one cycle
	task automatic run(input int c, input logic [11:0] a);
		u_sdram_ctrl_model.issue(PINS[c], a);
		repeat (2) @(negedge clk_sys_in);
		check(12'(c != 8), 12'(cmd_valid_out));
		check(12'(cmd_out), 12'(c % 8));
		if (c == 1)
			opn[a[11]] = 1'b1;
		if (c == 4)
			opn &= ~pre_banks(a);
		if (c >= 1 && c <= 3)
			check(12'(bank_select_out), 12'(a[11]));
		if (c == 1)
			check(12'(row_address_out), 12'(a[10:0]));
		if (c == 2 || c == 3)
			check(12'(column_address_out), 12'(a[9:0] & (10'h3FF >> (9 - CT))));
		if (c == 4)
			check(12'(precharge_banks_out), 12'(pre_banks(a)));
		check(12'(bank_open_out), 12'(opn));
	endtask

	// Counts written words and driven read cycles over one burst
	task automatic burst(input int c, input logic mk, input int e);
		int n = 0;
		int na = 0;
		u_sdram_ctrl_model.mask_out = mk;
		u_sdram_ctrl_model.issue(PINS[c], 12'h000);
		repeat (16) begin
			@(negedge clk_sys_in);
			n += (c == 3) ? write_strobe_out : data_oe_out;
			na += (c == 3) ? write_active_out : read_active_out;
		end
		u_sdram_ctrl_model.mask_out = 1'b0;
		check(12'(n), 12'(e));
		check(12'(na), 12'(burst_words(BL_8)));
	endtask

	task automatic summarize();
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Stops a hung run long after the tests should have ended
	initial begin
		#100000;
		n_fail++;
		summarize();
	end

	initial begin
		opn = 2'h0;
		repeat (5) @(negedge clk_sys_in);
		sys_rst_in = 1'b0;
		foreach (BLC[i]) begin
			m = {5'h00, 3'(2 + i % 2), 1'($random(seed)), BLC[i]};
			u_sdram_ctrl_model.set_mode(m);
			@(negedge clk_sys_in);
			check(12'(burst_len_out), 12'(m[2:0]));
			check(12'(cas_latency_out), 12'(m[6:4]));
			check(12'(burst_interleave_out), 12'(m[3] && m[2:0] != 3'h7));
		end
		$display("mode test done");
		burst(3, 1'b0, 8);
		burst(3, 1'b1, 0);
		burst(2, 1'b0, 8);
		burst(2, 1'b1, 0);
		$display("mask test done");
		run(1, 12'h800);
		run(1, 12'h0A5);
		run(2, 12'h3FF);
		run(4, 12'hC00);
		repeat (40) begin
			k = {$random(seed)} % 7;
			m = $random(seed);
			if (k == 6)
				k = 8;
			if (k == 2 || k == 3)
				m[10] = 1'b0;
			run(k, m);
		end
		$display("random test done");
		u_sdram_ctrl_model.gate_out = 1'b0;
		u_sdram_ctrl_model.issue(PINS[1], 12'h123);
		repeat (2) @(negedge clk_sys_in);
		check(12'(cmd_valid_out), 12'h000);
		u_sdram_ctrl_model.gate_out = 1'b1;
		run(4, 12'h400);
		run(6, 12'h000);
		check(12'(self_refresh_out), 12'h001);
		$display("gate test done");
		summarize();
	end
endmodule

bind sdram_command_interface sdram_cmd_properties #(.COL_TOP(COL_TOP)) u_sdram_cmd_properties (.*);
